//--- rtl/crtmaf_pkg.sv
// Constants, register indices and carrier types for the CRT mode block.
// Assumes one system clock; all pin inputs are asynchronous to it.
package crtmaf_pkg;
	localparam logic [4:0] REG_HTOTAL = 5'h00;
	localparam logic [4:0] REG_HDISP = 5'h01;
	localparam logic [4:0] REG_HSYNC_POS = 5'h02;
	localparam logic [4:0] REG_SYNC_WIDTH = 5'h03;
	localparam logic [4:0] REG_VTOTAL = 5'h04;
	localparam logic [4:0] REG_VDISP = 5'h06;
	localparam logic [4:0] REG_VSYNC_ROW = 5'h07;
	localparam logic [4:0] REG_MODE = 5'h08;
	localparam logic [4:0] REG_SCAN_MAX = 5'h09;
	localparam logic [4:0] REG_CUR_FIRST = 5'h0A;
	localparam logic [4:0] REG_CUR_LAST = 5'h0B;
	localparam logic [4:0] REG_START_HI = 5'h0C;
	localparam logic [4:0] REG_START_LO = 5'h0D;
	localparam logic [4:0] REG_CUR_HI = 5'h0E;
	localparam logic [4:0] REG_CUR_LO = 5'h0F;
	localparam logic [4:0] REG_PEN_HI = 5'h10;
	localparam logic [4:0] REG_PEN_LO = 5'h11;
	localparam logic [4:0] REG_UPD_HI = 5'h12;
	localparam logic [4:0] REG_UPD_LO = 5'h13;
	localparam logic [4:0] REG_DUMMY = 5'h1F;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [4:0] ADDR_RST = 5'h00;
	localparam int ST_UPD_READY = 7;
	localparam int ST_PEN_FULL = 6;
	localparam int ST_VBLANK = 5;
	// A zero vertical width field means sixteen lines
	localparam logic [4:0] VSYNC_WIDE = 5'h10;
	localparam logic [5:0] SCAN_STEP_ONE = 6'h01;
	localparam logic [5:0] SCAN_STEP_TWO = 6'h02;
	localparam int BLINK_FAST_BIT = 3;
	localparam int BLINK_SLOW_BIT = 4;

	typedef enum logic [1:0] {
		SCAN_PLAIN = 2'b00,
		SCAN_SYNC = 2'b01,
		SCAN_PLAIN_ALT = 2'b10,
		SCAN_VIDEO = 2'b11
	} crtmaf_scan_e;

	typedef enum logic [1:0] {
		UPD_IDLE = 2'b00,
		UPD_WAIT = 2'b01,
		UPD_STROBE = 2'b10
	} crtmaf_upd_e;

	typedef enum logic [1:0] {
		CUR_STEADY = 2'b00,
		CUR_OFF = 2'b01,
		CUR_FAST = 2'b10,
		CUR_SLOW = 2'b11
	} crtmaf_cur_e;

	typedef struct packed {
		logic xfer_sel;
		logic upstb_sel;
		logic cur_skew;
		logic den_skew;
		logic transparent;
		logic rowcol;
		crtmaf_scan_e scan;
	} crtmaf_mode_s;

	typedef struct packed {
		logic cs_n;
		logic rs;
		logic rw;
		logic e;
		logic character_clock;
		logic light_pen_input;
		logic [7:0] db;
	} crtmaf_pins_s;

	function automatic logic [13:0] crtmaf_pair(input logic [5:0] hi,
		input logic [7:0] lo);
		return {hi, lo};
	endfunction
endpackage

//--- rtl/crtmaf_skew.sv
// Per-lane optional one-character delay for display enable and cursor.
// Assumes tick_i is a one-cycle pulse per character clock.
`timescale 1ns/10ps
module crtmaf_skew #(
	parameter int W = 2
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic tick_i,
	input wire logic [W-1:0] data_i,
	input wire logic [W-1:0] delay_i,
	output logic [W-1:0] data_o
);
	logic [W-1:0] stage_reg;

	genvar g;
	generate
		for (g = 0; g < W; g++)
		begin : lane
			always_ff @(posedge clk_i)
			begin
				if (reset_i)
				begin
					stage_reg[g] <= 1'b0;
					data_o[g] <= 1'b0;
				end
				else
				begin
					if (tick_i)
						stage_reg[g] <= data_i[g];
					data_o[g] <= delay_i[g] ? stage_reg[g] : data_i[g];
				end
			end

			sequence tick_then_delay;
				(tick_i && delay_i[g]) ##1 delay_i[g];
			endsequence

			chk_skew_delay: assert property (@(posedge clk_i)
				disable iff (reset_i)
				tick_then_delay |=> data_o[g] == $past(data_i[g], 2))
				else $error("skewed lane not one character late");
			chk_skew_bypass: assert property (@(posedge clk_i)
				disable iff (reset_i)
				!delay_i[g] |=> data_o[g] == $past(data_i[g]))
				else $error("unskewed lane delayed");
		end
	endgenerate
endmodule

//--- rtl/crtmaf_top.sv
// CRT controller core: address formats, memory modes, scan modes, skew.
// Assumes host bus, character clock and light pen are asynchronous pins.
`timescale 1ns/10ps
module crtmaf_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cs_n_i,
	input wire logic rs_i,
	input wire logic rw_i,
	input wire logic e_i,
	input wire logic [7:0] db_i,
	output logic [7:0] db_o,
	output logic db_oe_o,
	input wire logic character_clock_i,
	input wire logic light_pen_input_i,
	output logic [13:0] ma_o,
	output logic [3:0] ra_o,
	output logic row_bit4_or_update_strobe_o,
	output logic hsync_o,
	output logic vsync_o,
	output logic display_enable_output_o,
	output logic cursor_o
);
	crtmaf_pkg::crtmaf_pins_s pins_now, sync_a_reg, sync_b_reg, prev_reg;
	logic [4:0] addr_reg;
	logic [7:0] htotal_reg, hdisp_reg, hsync_pos_reg, sync_width_register;
	logic [6:0] vtotal_reg, vdisp_reg, vertical_sync_row;
	logic [7:0] mode_control_register;
	logic [4:0] scan_max_reg, cursor_last_line;
	logic [6:0] cursor_first_line;
	logic [5:0] start_hi_reg, cur_hi_reg, pen_hi_reg, upd_hi_reg;
	logic [7:0] start_lo_reg, cur_lo_reg, pen_lo_reg, upd_lo_reg;
	logic [7:0] hcnt_reg;
	logic [4:0] scan_reg;
	logic [6:0] row_reg;
	logic [13:0] line_base_reg;
	logic field_reg;
	logic [4:0] blink_reg;
	logic [3:0] hs_left_reg;
	logic [4:0] vs_left_reg;
	logic pen_pend_reg, pen_full_reg, upd_ready_reg, upd_req_reg;
	crtmaf_pkg::crtmaf_upd_e upd_state_reg;
	crtmaf_pkg::crtmaf_mode_s mode;
	crtmaf_pkg::crtmaf_cur_e cur_mode;
	logic tick, e_fall, acc, wr, rd, reg_wr, dummy_acc, pen_rise;
	logic interlaced, video, line_end, row_last, frame_end, field_next;
	logic [5:0] scan_step, scan_sum;
	logic [4:0] scan_first;
	logic [7:0] vs_pos;
	logic [8:0] line_len;
	logic vs_start, den_raw, cur_raw, blink_on, strobe;
	logic [13:0] ma_lin, ma_rc, ma_disp, cursor_loc, upd_loc;
	logic [7:0] rd_mux;
	logic [1:0] skew_out;

	assign pins_now = '{cs_n: cs_n_i, rs: rs_i, rw: rw_i, e: e_i,
		character_clock: character_clock_i, light_pen_input: light_pen_input_i, db: db_i};

	// Every pin passes two stages; edges are taken from the second and third
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sync_a_reg <= '0;
			sync_b_reg <= '0;
			prev_reg <= '0;
		end
		else
		begin
			sync_a_reg <= pins_now;
			sync_b_reg <= sync_a_reg;
			prev_reg <= sync_b_reg;
		end
	end

	assign tick = sync_b_reg.character_clock & ~prev_reg.character_clock;
	assign e_fall = prev_reg.e & ~sync_b_reg.e;
	assign acc = e_fall & ~sync_b_reg.cs_n;
	assign wr = acc & ~sync_b_reg.rw;
	assign rd = acc & sync_b_reg.rw;
	assign reg_wr = wr & sync_b_reg.rs;
	assign pen_rise = sync_b_reg.light_pen_input & ~prev_reg.light_pen_input;
	assign mode = crtmaf_pkg::crtmaf_mode_s'(mode_control_register);
	assign cur_mode = crtmaf_pkg::crtmaf_cur_e'(cursor_first_line[6:5]);
	assign interlaced = mode.scan == crtmaf_pkg::SCAN_SYNC
		|| mode.scan == crtmaf_pkg::SCAN_VIDEO;
	assign video = mode.scan == crtmaf_pkg::SCAN_VIDEO;
	// Dummy location only requests an update in transparent mode
	assign dummy_acc = acc & sync_b_reg.rs & mode.transparent
		& addr_reg == crtmaf_pkg::REG_DUMMY;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			addr_reg <= crtmaf_pkg::ADDR_RST;
		else if (wr & ~sync_b_reg.rs)
			addr_reg <= sync_b_reg.db[4:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			htotal_reg <= crtmaf_pkg::REG_RST;
			hdisp_reg <= crtmaf_pkg::REG_RST;
			hsync_pos_reg <= crtmaf_pkg::REG_RST;
			sync_width_register <= crtmaf_pkg::REG_RST;
			vtotal_reg <= crtmaf_pkg::REG_RST[6:0];
			vdisp_reg <= crtmaf_pkg::REG_RST[6:0];
			vertical_sync_row <= crtmaf_pkg::REG_RST[6:0];
			mode_control_register <= crtmaf_pkg::REG_RST;
			scan_max_reg <= crtmaf_pkg::REG_RST[4:0];
			cursor_first_line <= crtmaf_pkg::REG_RST[6:0];
			cursor_last_line <= crtmaf_pkg::REG_RST[4:0];
			start_hi_reg <= crtmaf_pkg::REG_RST[5:0];
			start_lo_reg <= crtmaf_pkg::REG_RST;
			cur_hi_reg <= crtmaf_pkg::REG_RST[5:0];
			cur_lo_reg <= crtmaf_pkg::REG_RST;
		end
		else if (reg_wr)
		begin
			case (addr_reg)
				crtmaf_pkg::REG_HTOTAL: htotal_reg <= sync_b_reg.db;
				crtmaf_pkg::REG_HDISP: hdisp_reg <= sync_b_reg.db;
				crtmaf_pkg::REG_HSYNC_POS: hsync_pos_reg <= sync_b_reg.db;
				crtmaf_pkg::REG_SYNC_WIDTH: sync_width_register <= sync_b_reg.db;
				crtmaf_pkg::REG_VTOTAL: vtotal_reg <= sync_b_reg.db[6:0];
				crtmaf_pkg::REG_VDISP: vdisp_reg <= sync_b_reg.db[6:0];
				crtmaf_pkg::REG_VSYNC_ROW: vertical_sync_row <= sync_b_reg.db[6:0];
				crtmaf_pkg::REG_MODE: mode_control_register <= sync_b_reg.db;
				crtmaf_pkg::REG_SCAN_MAX: scan_max_reg <= sync_b_reg.db[4:0];
				crtmaf_pkg::REG_CUR_FIRST: cursor_first_line <= sync_b_reg.db[6:0];
				crtmaf_pkg::REG_CUR_LAST: cursor_last_line <= sync_b_reg.db[4:0];
				crtmaf_pkg::REG_START_HI: start_hi_reg <= sync_b_reg.db[5:0];
				crtmaf_pkg::REG_START_LO: start_lo_reg <= sync_b_reg.db;
				crtmaf_pkg::REG_CUR_HI: cur_hi_reg <= sync_b_reg.db[5:0];
				crtmaf_pkg::REG_CUR_LO: cur_lo_reg <= sync_b_reg.db;
				default: ;
			endcase
		end
	end

	// Raster counters; video alone steps two lines from the field parity, sync steps one
	assign scan_step = video ? crtmaf_pkg::SCAN_STEP_TWO
		: crtmaf_pkg::SCAN_STEP_ONE;
	assign scan_sum = {1'b0, scan_reg} + scan_step;
	assign line_end = hcnt_reg == htotal_reg;
	assign row_last = scan_sum > {1'b0, scan_max_reg};
	assign frame_end = line_end & row_last & row_reg == vtotal_reg;
	assign field_next = interlaced & (frame_end ? ~field_reg : field_reg);
	assign scan_first = video ? {4'h0, field_next} : 5'h00;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			hcnt_reg <= 8'h00;
			scan_reg <= 5'h00;
			row_reg <= 7'h00;
			line_base_reg <= 14'h0000;
			blink_reg <= 5'h00;
		end
		else if (tick)
		begin
			hcnt_reg <= line_end ? 8'h00 : hcnt_reg + 8'h01;
			if (line_end)
			begin
				scan_reg <= row_last ? scan_first : scan_sum[4:0];
				if (row_last)
					row_reg <= frame_end ? 7'h00 : row_reg + 7'h01;
			end
			if (frame_end)
			begin
				line_base_reg <= crtmaf_pkg::crtmaf_pair(start_hi_reg,
					start_lo_reg);
				blink_reg <= blink_reg + 5'h01;
			end
			else if (line_end & row_last)
				line_base_reg <= line_base_reg + {6'h00, hdisp_reg};
		end
	end

	// Non-interlaced modes hold the field at even
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			field_reg <= 1'b0;
		else if (!interlaced)
			field_reg <= 1'b0;
		else if (tick & frame_end)
			field_reg <= ~field_reg;
	end

	// Low nibble is horizontal width in characters, high nibble vertical
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			hs_left_reg <= 4'h0;
		else if (tick)
		begin
			if (hcnt_reg == hsync_pos_reg)
				hs_left_reg <= sync_width_register[3:0];
			else if (hs_left_reg != 4'h0)
				hs_left_reg <= hs_left_reg - 4'h1;
		end
	end

	// Odd interlaced fields start and end vertical sync mid-line
	// Half of the full line, htotal plus one characters
	assign line_len = {1'b0, htotal_reg} + 9'h001;
	assign vs_pos = (interlaced & field_reg) ? line_len[8:1]
		: 8'h00;
	assign vs_start = row_reg == vertical_sync_row + 7'h01
		&& scan_reg == (video ? {4'h0, field_reg} : 5'h00);

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			vs_left_reg <= 5'h00;
		else if (tick && hcnt_reg == vs_pos)
		begin
			if (vs_left_reg != 5'h00)
				vs_left_reg <= vs_left_reg - 5'h01;
			else if (vs_start)
				vs_left_reg <= sync_width_register[7:4] == 4'h0
					? crtmaf_pkg::VSYNC_WIDE
					: {1'b0, sync_width_register[7:4]};
		end
	end

	// Display address in the selected format
	assign ma_lin = line_base_reg + {6'h00, hcnt_reg};
	assign ma_rc = {start_hi_reg + row_reg[5:0], start_lo_reg + hcnt_reg};
	assign ma_disp = mode.rowcol ? ma_rc : ma_lin;
	assign cursor_loc = crtmaf_pkg::crtmaf_pair(cur_hi_reg, cur_lo_reg);
	assign upd_loc = crtmaf_pkg::crtmaf_pair(upd_hi_reg, upd_lo_reg);
	assign den_raw = hcnt_reg < hdisp_reg && row_reg < vdisp_reg;
	always_comb
	begin
		unique case (cur_mode)
			crtmaf_pkg::CUR_STEADY: blink_on = 1'b1;
			crtmaf_pkg::CUR_OFF: blink_on = 1'b0;
			crtmaf_pkg::CUR_FAST: blink_on = blink_reg[crtmaf_pkg::BLINK_FAST_BIT];
			crtmaf_pkg::CUR_SLOW: blink_on = blink_reg[crtmaf_pkg::BLINK_SLOW_BIT];
		endcase
	end
	// Plain range compare, so either parity works in sync and video
	assign cur_raw = blink_on && den_raw && ma_disp == cursor_loc
		&& scan_reg >= cursor_first_line[4:0]
		&& scan_reg <= cursor_last_line;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			pen_pend_reg <= 1'b0;
			pen_full_reg <= 1'b0;
			pen_hi_reg <= crtmaf_pkg::REG_RST[5:0];
			pen_lo_reg <= crtmaf_pkg::REG_RST;
		end
		else
		begin
			if (pen_rise)
				pen_pend_reg <= 1'b1;
			else if (tick)
				pen_pend_reg <= 1'b0;
			if (tick & pen_pend_reg)
			begin
				pen_hi_reg <= ma_disp[13:8];
				pen_lo_reg <= ma_disp[7:0];
			end
			// Capture wins over the clearing read
			if (tick & pen_pend_reg)
				pen_full_reg <= 1'b1;
			else if (rd & sync_b_reg.rs & addr_reg == crtmaf_pkg::REG_PEN_LO)
				pen_full_reg <= 1'b0;
		end
	end

	// Transparent updates run in the character after a blanked one, never in shared mode
	assign strobe = upd_state_reg == crtmaf_pkg::UPD_STROBE;
	always_ff @(posedge clk_i)
	begin
		if (reset_i | ~mode.transparent)
			upd_state_reg <= crtmaf_pkg::UPD_IDLE;
		else
		begin
			unique case (upd_state_reg)
				crtmaf_pkg::UPD_IDLE:
					if (upd_req_reg)
						upd_state_reg <= crtmaf_pkg::UPD_WAIT;
				crtmaf_pkg::UPD_WAIT:
					if (tick & ~den_raw)
						upd_state_reg <= crtmaf_pkg::UPD_STROBE;
				crtmaf_pkg::UPD_STROBE:
					if (tick)
						upd_state_reg <= crtmaf_pkg::UPD_IDLE;
				default: upd_state_reg <= crtmaf_pkg::UPD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			upd_req_reg <= 1'b0;
			upd_ready_reg <= 1'b0;
			upd_hi_reg <= crtmaf_pkg::REG_RST[5:0];
			upd_lo_reg <= crtmaf_pkg::REG_RST;
		end
		else
		begin
			if (dummy_acc)
				upd_req_reg <= 1'b1;
			else if (upd_state_reg != crtmaf_pkg::UPD_IDLE || !mode.transparent)
				upd_req_reg <= 1'b0;
			if (strobe & tick)
				upd_ready_reg <= 1'b1;
			else if (dummy_acc)
				upd_ready_reg <= 1'b0;
			// Row/column format steps the column only
			if (strobe & tick)
				{upd_hi_reg, upd_lo_reg} <= mode.rowcol
					? {upd_hi_reg, upd_lo_reg + 8'h01}
					: upd_loc + 14'h0001;
			else if (reg_wr && addr_reg == crtmaf_pkg::REG_UPD_HI)
				upd_hi_reg <= sync_b_reg.db[5:0];
			else if (reg_wr && addr_reg == crtmaf_pkg::REG_UPD_LO)
				upd_lo_reg <= sync_b_reg.db;
		end
	end

	always_comb
	begin
		rd_mux = 8'h00;
		if (!sync_b_reg.rs)
		begin
			rd_mux[crtmaf_pkg::ST_UPD_READY] = upd_ready_reg;
			rd_mux[crtmaf_pkg::ST_PEN_FULL] = pen_full_reg;
			rd_mux[crtmaf_pkg::ST_VBLANK] = row_reg >= vdisp_reg;
		end
		else if (addr_reg == crtmaf_pkg::REG_CUR_HI)
			rd_mux = {2'b00, cur_hi_reg};
		else if (addr_reg == crtmaf_pkg::REG_CUR_LO)
			rd_mux = cur_lo_reg;
		else if (addr_reg == crtmaf_pkg::REG_PEN_HI)
			rd_mux = {2'b00, pen_hi_reg};
		else if (addr_reg == crtmaf_pkg::REG_PEN_LO)
			rd_mux = pen_lo_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			db_o <= 8'h00;
			db_oe_o <= 1'b0;
			ma_o <= 14'h0000;
			ra_o <= 4'h0;
			row_bit4_or_update_strobe_o <= 1'b0;
			hsync_o <= 1'b0;
			vsync_o <= 1'b0;
		end
		else
		begin
			db_o <= rd_mux;
			db_oe_o <= sync_b_reg.e & ~sync_b_reg.cs_n & sync_b_reg.rw
				& ~(sync_b_reg.rs & addr_reg == crtmaf_pkg::REG_DUMMY);
			ma_o <= strobe ? upd_loc : ma_disp;
			ra_o <= scan_reg[3:0];
			row_bit4_or_update_strobe_o <= mode.upstb_sel ? strobe : scan_reg[4];
			hsync_o <= hs_left_reg != 4'h0;
			vsync_o <= vs_left_reg != 5'h00;
		end
	end

	crtmaf_skew #(
		.W(2)
	) u_skew (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.tick_i(tick),
		.data_i({cur_raw, den_raw}),
		.delay_i({mode.cur_skew, mode.den_skew}),
		.data_o(skew_out)
	);
	assign display_enable_output_o = skew_out[0];
	assign cursor_o = skew_out[1];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	chk_linear_addr: assert property (!mode.rowcol && !strobe
		|=> ma_o == $past(line_base_reg) + {6'h00, $past(hcnt_reg)})
		else $error("linear address not base plus column");
	chk_rowcol_addr: assert property (mode.rowcol && !strobe
		|=> ma_o[7:0] == $past(start_lo_reg) + $past(hcnt_reg))
		else $error("row/column low byte not column");
	chk_shared_idle: assert property (!mode.transparent
		|=> upd_state_reg == crtmaf_pkg::UPD_IDLE)
		else $error("update cycle in shared mode");
	chk_update_step: assert property (strobe && tick && !mode.rowcol
		&& mode.transparent |=> upd_loc == $past(upd_loc) + 14'h0001)
		else $error("update location did not advance by one");
	chk_field_even: assert property (!interlaced |=> !field_reg)
		else $error("field toggled without interlace");
	chk_field_flip: assert property (tick && frame_end && interlaced
		|=> field_reg != $past(field_reg))
		else $error("field did not flip at frame end");
	chk_vsync_half: assert property ($rose(vs_left_reg != 5'h00)
		|-> $past(hcnt_reg) == $past(vs_pos))
		else $error("vertical sync started off position");
	chk_vsync_plain: assert property (!interlaced
		##1 $rose(vs_left_reg != 5'h00) |-> $past(hcnt_reg) == 8'h00)
		else $error("non-interlaced sync not at line start");
endmodule

//--- dv/crtmaf_crt_model.sv
// Far side of the raster: character oscillator and pen-less monitor.
// Assumes the system clock runs at least six times the character rate.
`timescale 1ns/10ps
module crtmaf_crt_model #(
	parameter int HALF = 4
) (
	input wire logic clk_i,
	output logic character_clock_o,
	output logic light_pen_input_o
);
	int n;
	initial
	begin
		character_clock_o = 1'h0;
		n = 0;
	end
	// Character oscillator runs free, monitors need it between frames too
	always @(posedge clk_i)
	begin
		n <= (n == HALF - 1) ? 0 : n + 1;
		if (n == HALF - 1)
			character_clock_o <= ~character_clock_o;
	end
	// This monitor has no light pen, so the pen input is held low
	assign light_pen_input_o = 1'h0;
endmodule

//--- dv/crtmaf_top_tb.sv
// Self-checking bench: host register access, address formats, scan modes.
// Assumes the partner model supplies the character clock pin.
`timescale 1ns/10ps
module crtmaf_top_tb;
	localparam int P = 8;
	localparam int HT = 9;
	logic clk_i, reset_i, smp, watch, den_d, stb_d, character_clock, light_pen_input;
	crtmaf_pkg::crtmaf_pins_s p;
	crtmaf_pkg::crtmaf_mode_s m;
	logic [7:0] db_o;
	logic db_oe_o, stb_o, hsync_o, vsync_o, den_o, cur_o;
	logic [13:0] ma_o, st;
	logic [3:0] ra_o;
	logic [18:0] xm;
	logic [8:0] qr[$];
	logic [18:0] qm[$];
	logic [13:0] qu[$];
	int mismatches, n_checks, cyc, seed, d0, d1;

	crtmaf_top DUT (.clk_i(clk_i), .reset_i(reset_i), .cs_n_i(p.cs_n),
		.rs_i(p.rs), .rw_i(p.rw), .e_i(p.e), .db_i(p.db), .db_o(db_o),
		.db_oe_o(db_oe_o), .character_clock_i(character_clock),
		.light_pen_input_i(light_pen_input), .ma_o(ma_o), .ra_o(ra_o),
		.row_bit4_or_update_strobe_o(stb_o), .hsync_o(hsync_o),
		.vsync_o(vsync_o), .display_enable_output_o(den_o),
		.cursor_o(cur_o));
	crtmaf_crt_model #(.HALF(P / 2)) CRT (.clk_i(clk_i), .character_clock_o(character_clock),
		.light_pen_input_o(light_pen_input));

	initial
	begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Pins held a full sync delay either side of the strobe edge
	task automatic bus(input logic rs, input logic rw, input logic [7:0] d);
		p.cs_n <= 1'h0;
		p.rs <= rs;
		p.rw <= rw;
		p.db <= d;
		p.e <= 1'h1;
		repeat (4) @(posedge clk_i);
		smp <= rw;
		@(posedge clk_i);
		smp <= 1'h0;
		p.e <= 1'h0;
		repeat (4) @(posedge clk_i);
		p.cs_n <= 1'h1;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'h0, 1'h0, {3'h0, a});
		bus(1'h1, 1'h0, d);
	endtask

	task automatic wr2(input logic [4:0] a, input logic [13:0] v);
		wr(a, {2'h0, v[13:8]});
		wr(a + 5'h01, v[7:0]);
	endtask

	task automatic rd(input logic [4:0] a, input logic [8:0] x);
		bus(1'h0, 1'h0, {3'h0, a});
		qr.push_back(x);
		bus(1'h1, 1'h1, 8'h00);
	endtask

	task automatic waitv(input logic v);
		for (int k = 0; k < 2000 && vsync_o !== v; k++)
			@(negedge clk_i);
		check(32'(vsync_o === v), 1);
	endtask

	// Cycles from the latest hsync rise to a rise of den, cursor or vsync
	task automatic gap(input int sel, output int d);
		int n;
		logic pv, cv, hp;
		n = -1;
		d = -1;
		pv = 1'h1;
		hp = 1'h1;
		// No count until an hsync rise has been seen
		for (int k = 0; k < 3000 && d < 0; k++)
		begin
			@(negedge clk_i);
			cv = sel == 0 ? den_o : sel == 1 ? cur_o : vsync_o;
			if (hsync_o && !hp)
				n = 0;
			else if (n >= 0)
				n++;
			if (cv && !pv && n >= 0)
				d = n;
			pv = cv;
			hp = hsync_o;
		end
		check(32'(d < 0), 0);
	endtask

	task automatic frame(input logic rc, input logic vid);
		int ns;
		ns = vid ? 1 : 2;
		waitv(1'h1);
		waitv(1'h0);
		for (int r = 0; r < 3; r++)
			for (int s = 0; s < ns; s++)
				qm.push_back({~vid, 4'(s), rc ?
					{st[13:8] + 6'(r), st[7:0]} :
					st + 14'(r * 6)});
		watch <= 1'h1;
		waitv(1'h1);
		watch <= 1'h0;
		check(32'(qm.size()), 0);
	endtask

	// Results are matched against the oldest note as they appear
	always @(negedge clk_i)
	begin
		den_d <= den_o;
		stb_d <= stb_o;
		cyc <= cyc + 1;
		if (cyc > 60000)
		begin
			mismatches++;
			summarize();
		end
		if (smp && qr.size() > 0)
			check({db_oe_o, db_o}, qr.pop_front());
		if (watch && den_o && !den_d)
		begin
			xm = qm.size() > 0 ? qm.pop_front() : 19'h7FFFF;
			check(ma_o, xm[13:0]);
			if (xm[18])
				check(ra_o, xm[17:14]);
		end
		if (stb_o && !stb_d)
			check(ma_o, qu.size() > 0 ? qu.pop_front() : 14'h3FFF);
	end

	initial
	begin
		p = '0;
		p.cs_n = 1'h1;
		{smp, watch, den_d, stb_d} = 4'h0;
		{mismatches, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
		seed = 42337;
		reset_i = 1'h1;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		rd(crtmaf_pkg::REG_CUR_HI, 9'h100);
		st = 14'($random(seed));
		wr2(crtmaf_pkg::REG_CUR_HI, st);
		rd(crtmaf_pkg::REG_CUR_HI, {3'h4, st[13:8]});
		rd(crtmaf_pkg::REG_CUR_LO, {1'h1, st[7:0]});
		wr(crtmaf_pkg::REG_START_HI, 8'h3F);
		rd(crtmaf_pkg::REG_START_HI, 9'h100);
		wr(crtmaf_pkg::REG_PEN_LO, 8'hFF);
		rd(crtmaf_pkg::REG_PEN_LO, 9'h100);
		rd(crtmaf_pkg::REG_DUMMY, 9'h000);
		rd(crtmaf_pkg::REG_MODE, 9'h100);
		wr(crtmaf_pkg::REG_HTOTAL, 8'(HT));
		wr(crtmaf_pkg::REG_HDISP, 8'h06);
		wr(crtmaf_pkg::REG_HSYNC_POS, 8'h07);
		wr(crtmaf_pkg::REG_SYNC_WIDTH, 8'h12);
		// Vsync row is not the last row, so it ends before row 0
		wr(crtmaf_pkg::REG_VTOTAL, 8'h05);
		wr(crtmaf_pkg::REG_VDISP, 8'h03);
		wr(crtmaf_pkg::REG_VSYNC_ROW, 8'h03);
		wr(crtmaf_pkg::REG_SCAN_MAX, 8'h01);
		wr2(crtmaf_pkg::REG_CUR_FIRST, 14'h0001);
		for (int i = 0; i < 4; i++)
		begin
			st = {5'h00, 3'($random(seed)), 6'h00} | 14'($random(seed) & 255);
			wr2(crtmaf_pkg::REG_START_HI, st);
			m = '0;
			m.rowcol = 1'(i & 1);
			m.scan = i > 1 ? crtmaf_pkg::SCAN_VIDEO : crtmaf_pkg::SCAN_PLAIN;
			wr(crtmaf_pkg::REG_MODE, m);
			frame(m.rowcol, 1'(i > 1));
		end
		wr2(crtmaf_pkg::REG_START_HI, 14'h0000);
		wr2(crtmaf_pkg::REG_CUR_HI, 14'h0001);
		for (int i = 0; i < 2; i++)
		begin
			m = '0;
			wr(crtmaf_pkg::REG_MODE, m);
			gap(i, d0);
			m.den_skew = 1'(i == 0);
			m.cur_skew = 1'(i == 1);
			wr(crtmaf_pkg::REG_MODE, m);
			gap(i, d1);
			check(32'(d1 - d0), P);
		end
		for (int i = 0; i < 4; i++)
		begin
			m = '0;
			m.scan = crtmaf_pkg::crtmaf_scan_e'(i[1:0]);
			wr(crtmaf_pkg::REG_MODE, m);
			gap(2, d0);
			gap(2, d1);
			check(32'(d0 > d1 ? d0 - d1 : d1 - d0),
				i[0] ? ((HT + 1) / 2) * P : 0);
		end
		for (int i = 0; i < 3; i++)
		begin
			m = '0;
			m.rowcol = 1'(i == 1);
			m.transparent = 1'(i < 2);
			m.upstb_sel = 1'h1;
			wr(crtmaf_pkg::REG_MODE, m);
			wr2(crtmaf_pkg::REG_UPD_HI, 14'h12FF);
			if (i < 2)
				qu.push_back(14'h12FF);
			if (i < 2)
				qu.push_back(i == 1 ? 14'h1200 : 14'h1300);
			repeat (2)
			begin
				wr(crtmaf_pkg::REG_DUMMY, 8'h00);
				repeat (200) @(posedge clk_i);
			end
			check(32'(qu.size()), 0);
		end
		summarize();
	end
endmodule
